/* tcd_decoder.sv */
// multi-purpose command decoder with training FIFO data path
`timescale 1ns/1ps
`default_nettype none
module tcd_decoder #(
   parameter int DQ_W = 16,
   parameter int RL = 6,
   parameter int WL = 4,
   parameter int BUF_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cke_pin,
   input wire logic cs_pin,
   input wire logic [tcd_pkg::CA_W-1:0] ca_pin,
   input wire logic [DQ_W-1:0] data_rx,
   output logic [DQ_W-1:0] data_tx,
   output logic data_en_b,
   input wire logic [tcd_pkg::MASK_W-1:0] mask_inversion_line_rx,
   output logic [tcd_pkg::MASK_W-1:0] mask_inversion_line_tx,
   output logic mask_inversion_line_en_b,
   input wire logic [tcd_pkg::PAT_W-1:0] first_pattern_register,
   input wire logic [tcd_pkg::PAT_W-1:0] second_pattern_register,
   input wire logic [DQ_W-1:0] invert_mask,
   input wire logic wr_inv_en,
   input wire logic rd_inv_en,
   input wire logic data_mask_en,
   output logic osc_running,
   output logic [tcd_pkg::RES_W-1:0] oscillator_result_low,
   output logic [tcd_pkg::RES_W-1:0] oscillator_result_high,
   output logic impedance_calibration_start,
   output logic impedance_calibration_latch
);
   import tcd_pkg::*;
   localparam int LAT_W = (RL > WL) ? RL : WL;
   localparam int SW = DQ_W + MASK_W;
   localparam int BW = SW + 1;
   typedef struct packed {
      logic [1:0] cke_s;
      logic [1:0] cs_s;
      logic [1:0][CA_W-1:0] ca_s;
      logic [1:0][DQ_W-1:0] dq_s;
      logic [1:0][MASK_W-1:0] mk_s;
      logic cke_prev;
      tcd_cmd_e cmd_st;
      logic op6;
      tcd_train_e train_pend;
      logic [LAT_W-1:0] rd_line;
      logic [LAT_W-1:0] wr_line;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [ENTRIES-1:0][BURST_LEN-1:0][SW-1:0] store;
      logic wr_act;
      logic [BEAT_W-1:0] wr_beat;
      logic [PTR_W-1:0] wr_entry;
      logic pf_act;
      logic pf_cal;
      logic [PTR_W-1:0] pf_entry;
      logic [BEAT_W-1:0] pf_beat;
      logic pend_v;
      logic pend_cal;
      logic [PTR_W-1:0] pend_entry;
      logic rd_act;
      logic [BEAT_W-1:0] rd_beat;
      logic [DQ_W-1:0] data_tx;
      logic data_en_b;
      logic [MASK_W-1:0] mask_tx;
      logic mask_en_b;
      logic osc_run;
      logic [OSC_W-1:0] osc_cnt;
      logic [RES_W-1:0] res_lo;
      logic [RES_W-1:0] res_hi;
      logic zq_start;
      logic zq_latch;
   } tcd_state_s;
   tcd_state_s r;
   tcd_state_s n;
   tcd_stream_if #(.W(BW)) fill_if ();
   tcd_stream_if #(.W(BW)) drain_if ();
   logic cke_ok;
   logic cs;
   logic [CA_W-1:0] ca;
   logic [OP_W-1:0] op;
   logic mpc_fire;
   logic cas_fire;
   logic disturb;
   logic known_op;
   logic rd_new;
   logic rd_new_cal;
   logic pat_bit;
   logic [BW-1:0] pf_word;

   // read words queue here so the prefetch may run ahead of the data phase
   tcd_fifo #(.W(BW), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(clk),
      .rst_b(rst_b),
      .fill(fill_if.snk),
      .drain(drain_if.src)
   );

   // synchronised pin views; stage 0 feeds only stage 1
   assign cs = r.cs_s[1];
   assign ca = r.ca_s[1];
   assign cke_ok = r.cke_s[1] && r.cke_prev;
   assign op = {r.op6, ca};
   assign known_op = (op == OP_RD_FIFO) || (op == OP_RD_CAL) || (op == OP_WR_FIFO)
      || (op == OP_OSC_START) || (op == OP_OSC_STOP) || (op == OP_ZQ_START)
      || (op == OP_ZQ_LATCH);

   // pattern bit: first register for beats 0-7, second for 8-15
   assign pat_bit = r.pf_beat[BEAT_W-1] ? second_pattern_register[r.pf_beat[2:0]]
      : first_pattern_register[r.pf_beat[2:0]];

   // prefetch word: drive flag, mask lines, data lines
   always_comb begin
      pf_word = '0;
      if (r.pf_cal) begin
         pf_word = {1'b1, {MASK_W{pat_bit}}, {DQ_W{pat_bit}} ^ invert_mask};
      end else begin
         // mask lines driven when any inversion or masking is on
         pf_word = {wr_inv_en | rd_inv_en | data_mask_en, r.store[r.pf_entry][r.pf_beat]};
      end
   end
   assign fill_if.valid = r.pf_act;
   assign fill_if.data = pf_word;
   // pops run exactly in the read data phase
   assign drain_if.ready = r.rd_line[RL-2] | r.rd_act;

   // next-state logic for decode, pointers, bursts and oscillator
   always_comb begin
      n = r;
      n.cke_s = {r.cke_s[0], cke_pin};
      n.cs_s = {r.cs_s[0], cs_pin};
      n.ca_s = {r.ca_s[0], ca_pin};
      n.dq_s = {r.dq_s[0], data_rx};
      n.mk_s = {r.mk_s[0], mask_inversion_line_rx};
      n.cke_prev = r.cke_s[1];
      n.zq_start = 1'b0;
      n.zq_latch = 1'b0;
      mpc_fire = 1'b0;
      cas_fire = 1'b0;
      rd_new = 1'b0;
      rd_new_cal = 1'b0;
      disturb = !r.cke_s[1];
      // two-edge capture of command and operand
      unique case (r.cmd_st)
         TCD_CMD_IDLE: begin
            if (cke_ok && cs) begin
               if (ca[4:0] == CODE_MPC) begin
                  n.cmd_st = TCD_CMD_MPC2;
                  n.op6 = ca[OP6_BIT-1];
               end else if (ca[4:0] == CODE_CAS2) begin
                  n.cmd_st = TCD_CMD_CAS2;
               end else begin
                  // any other command cancels a pending training action
                  n.train_pend = TCD_TR_NONE;
                  // ordinary column commands disturb the pointers
                  if ((ca[4:0] == CODE_WR) || (ca[4:0] == CODE_MWR)
                     || (ca[4:0] == CODE_RD) || (ca[4:0] == CODE_MRR)) begin
                     disturb = 1'b1;
                  end
               end
            end
         end
         TCD_CMD_MPC2: begin
            n.cmd_st = TCD_CMD_IDLE;
            mpc_fire = cke_ok && !cs;
         end
         TCD_CMD_CAS2: begin
            n.cmd_st = TCD_CMD_IDLE;
            cas_fire = cke_ok && !cs;
         end
      endcase

      // oscillator stand-in counter, saturates; a start below overrides it
      if (r.osc_run && (r.osc_cnt != OSC_MAX)) begin
         n.osc_cnt = r.osc_cnt + 1'b1;
      end

      // bit 6 low leaves everything alone but ends a pending action
      if (mpc_fire) begin
         n.train_pend = TCD_TR_NONE;
         if (r.op6) begin
            // training actions; only the FIFO read, the calibration read and the FIFO write wait for a column command
            unique case (op)
               OP_RD_FIFO: n.train_pend = TCD_TR_RD_FIFO;
               OP_RD_CAL: n.train_pend = TCD_TR_RD_CAL;
               OP_WR_FIFO: n.train_pend = TCD_TR_WR_FIFO;
               OP_OSC_START: begin
                  n.osc_run = 1'b1;
                  n.osc_cnt = '0;
               end
               // stop stores the count into the result pair
               OP_OSC_STOP: begin
                  if (r.osc_run) begin
                     n.osc_run = 1'b0;
                     {n.res_hi, n.res_lo} = r.osc_cnt;
                  end
               end
               OP_ZQ_START: n.zq_start = 1'b1;
               OP_ZQ_LATCH: n.zq_latch = 1'b1;
               default: n.train_pend = TCD_TR_NONE;
            endcase
         end
      end

      // column operands are not read; only the pending action counts
      if (cas_fire) begin
         n.train_pend = TCD_TR_NONE;
         unique case (r.train_pend)
            TCD_TR_RD_FIFO: rd_new = 1'b1;
            TCD_TR_RD_CAL: begin
               rd_new = 1'b1;
               rd_new_cal = 1'b1;
               // calibration read also disturbs the pointers
               disturb = 1'b1;
            end
            default: n.train_pend = TCD_TR_NONE;
         endcase
      end

      // latency lines start at the column command's second edge
      n.rd_line = {r.rd_line[LAT_W-2:0], rd_new};
      n.wr_line = {r.wr_line[LAT_W-2:0], cas_fire && (r.train_pend == TCD_TR_WR_FIFO)};

      // write data taken after write latency, 16 beats
      if (r.wr_act) begin
         n.store[r.wr_entry][r.wr_beat] = {r.mk_s[1], r.dq_s[1]};
         n.wr_beat = r.wr_beat + 1'b1;
         if (r.wr_beat == BEAT_LAST) begin
            n.wr_act = 1'b0;
         end
      end
      // a new burst may start on the last beat of the previous one
      if (r.wr_line[WL-1]) begin
         n.store[r.wr_ptr][0] = {r.mk_s[1], r.dq_s[1]};
         n.wr_act = 1'b1;
         n.wr_beat = BEAT_ONE;
         n.wr_entry = r.wr_ptr;
         // five entries, the sixth write lands on the first
         n.wr_ptr = (r.wr_ptr == PTR_LAST) ? PTR_FIRST : r.wr_ptr + 1'b1;
      end

      // prefetch walks one beat per accepted push, stalls on a full buffer
      if (r.pf_act && fill_if.ready) begin
         n.pf_beat = r.pf_beat + 1'b1;
         if (r.pf_beat == BEAT_LAST) begin
            n.pf_act = r.pend_v;
            n.pf_cal = r.pend_cal;
            n.pf_entry = r.pend_entry;
            n.pend_v = 1'b0;
         end
      end
      if (rd_new) begin
         if (!n.pf_act) begin
            n.pf_act = 1'b1;
            n.pf_cal = rd_new_cal;
            n.pf_entry = r.rd_ptr;
            n.pf_beat = '0;
         end else begin
            n.pend_v = 1'b1;
            n.pend_cal = rd_new_cal;
            n.pend_entry = r.rd_ptr;
         end
         // read pointer advances and wraps after five
         if (!rd_new_cal) begin
            n.rd_ptr = (r.rd_ptr == PTR_LAST) ? PTR_FIRST : r.rd_ptr + 1'b1;
         end
      end

      // read data phase, one word per cycle
      if (r.rd_line[RL-2]) begin
         n.rd_act = 1'b1;
         n.rd_beat = BEAT_ONE;
      end else if (r.rd_act) begin
         n.rd_beat = r.rd_beat + 1'b1;
         // seamless: the next start overrides this end
         if (r.rd_beat == BEAT_LAST) begin
            n.rd_act = 1'b0;
         end
      end
      // burst length fixed at 16 whatever the burst setting
      if (drain_if.ready && drain_if.valid) begin
         {n.mask_tx, n.data_tx} = drain_if.data[SW-1:0];
         n.data_en_b = 1'b0;
         n.mask_en_b = !drain_if.data[SW];
      end else begin
         n.data_en_b = 1'b1;
         n.mask_en_b = 1'b1;
      end

      // pointer disturbance wins over any advance this cycle
      if (disturb) begin
         n.wr_ptr = PTR_FIRST;
         n.rd_ptr = PTR_FIRST;
      end
   end

   // state register; pins idle undriven in reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.data_en_b <= 1'b1;
         r.mask_en_b <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign data_tx = r.data_tx;
   assign data_en_b = r.data_en_b;
   assign mask_inversion_line_tx = r.mask_tx;
   assign mask_inversion_line_en_b = r.mask_en_b;
   assign osc_running = r.osc_run;
   assign oscillator_result_low = r.res_lo;
   assign oscillator_result_high = r.res_hi;
   assign impedance_calibration_start = r.zq_start;
   assign impedance_calibration_latch = r.zq_latch;

   // checks on decode and data path
   property p_nop_quiet;
      @(posedge clk) disable iff (!rst_b)
      (mpc_fire && !r.op6) |=> (r.train_pend == TCD_TR_NONE) && $stable(r.osc_run);
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("no-op changed state");
   property p_rd_decode;
      @(posedge clk) disable iff (!rst_b)
      (mpc_fire && (op == OP_RD_FIFO)) |=> (r.train_pend == TCD_TR_RD_FIFO);
   endproperty
   a_rd_decode: assert property (p_rd_decode) else $error("fifo read not pending");
   property p_osc_start;
      @(posedge clk) disable iff (!rst_b)
      (mpc_fire && (op == OP_OSC_START)) |=> osc_running && (r.osc_cnt == '0);
   endproperty
   a_osc_start: assert property (p_osc_start) else $error("oscillator not started");
   property p_zq_latch;
      @(posedge clk) disable iff (!rst_b)
      (mpc_fire && (op == OP_ZQ_LATCH)) |=> r.zq_latch ##1 !r.zq_latch;
   endproperty
   a_zq_latch: assert property (p_zq_latch) else $error("latch pulse wrong");
   property p_rd_latency;
      @(posedge clk) disable iff (!rst_b)
      r.rd_line[RL-2] |=> !data_en_b;
   endproperty
   a_rd_latency: assert property (p_rd_latency) else $error("read data late");
   property p_burst_hold;
      @(posedge clk) disable iff (!rst_b)
      $fell(data_en_b) |-> !data_en_b [*8];
   endproperty
   a_burst_hold: assert property (p_burst_hold) else $error("burst cut short");
   property p_wr_wrap;
      @(posedge clk) disable iff (!rst_b)
      (r.wr_line[WL-1] && (r.wr_ptr == PTR_LAST)) |=> (r.wr_ptr == PTR_FIRST);
   endproperty
   a_wr_wrap: assert property (p_wr_wrap) else $error("write pointer did not wrap");
   property p_rd_wrap;
      @(posedge clk) disable iff (!rst_b)
      (rd_new && !rd_new_cal && (r.rd_ptr == PTR_LAST)) |=> (r.rd_ptr == PTR_FIRST);
   endproperty
   a_rd_wrap: assert property (p_rd_wrap) else $error("read pointer did not wrap");
   property p_disturb;
      @(posedge clk) disable iff (!rst_b)
      disturb |=> (r.wr_ptr == PTR_FIRST) && (r.rd_ptr == PTR_FIRST);
   endproperty
   a_disturb: assert property (p_disturb) else $error("pointers not reset");
   property p_mask_drive;
      @(posedge clk) disable iff (!rst_b)
      (drain_if.ready && drain_if.valid && drain_if.data[SW]) |=> !mask_inversion_line_en_b;
   endproperty
   a_mask_drive: assert property (p_mask_drive) else $error("mask lines not driven");
   property p_osc_store;
      @(posedge clk) disable iff (!rst_b)
      (mpc_fire && (op == OP_OSC_STOP) && r.osc_run)
         |=> ({oscillator_result_high, oscillator_result_low} == $past(r.osc_cnt)) && !osc_running;
   endproperty
   a_osc_store: assert property (p_osc_store) else $error("result not stored");
   property p_reserved;
      @(posedge clk) disable iff (!rst_b)
      (mpc_fire && r.op6 && !known_op) |=> $stable(r.osc_run) && (r.train_pend == TCD_TR_NONE);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code acted");
endmodule // tcd_decoder
`default_nettype wire

/* tcd_pkg.sv */
// constants and types shared by the training command decoder and its buffer
package tcd_pkg;
   localparam int BURST_LEN = 16;
   localparam int BEAT_W = 4;
   localparam logic [BEAT_W-1:0] BEAT_LAST = 4'hf;
   localparam logic [BEAT_W-1:0] BEAT_ONE = 4'h1;
   localparam int ENTRIES = 5;
   localparam int PTR_W = 3;
   localparam logic [PTR_W-1:0] PTR_FIRST = 3'h0;
   localparam logic [PTR_W-1:0] PTR_LAST = 3'h4;
   localparam int CA_W = 6;
   localparam int OP_W = 7;
   localparam int MASK_W = 2;
   localparam int PAT_W = 8;
   localparam int OSC_W = 16;
   localparam int RES_W = 8;
   localparam logic [OSC_W-1:0] OSC_MAX = 16'hffff;
   // first-edge codes on ca[4:0] with chip select high
   localparam logic [4:0] CODE_MPC = 5'h00;
   localparam logic [4:0] CODE_CAS2 = 5'h12;
   localparam logic [4:0] CODE_WR = 5'h04;
   localparam logic [4:0] CODE_MWR = 5'h0c;
   localparam logic [4:0] CODE_RD = 5'h02;
   localparam logic [4:0] CODE_MRR = 5'h0e;
   // command_operand codes with bit 6 set
   localparam int OP6_BIT = 6;
   localparam logic [OP_W-1:0] OP_RD_FIFO = 7'h41;
   localparam logic [OP_W-1:0] OP_RD_CAL = 7'h43;
   localparam logic [OP_W-1:0] OP_WR_FIFO = 7'h47;
   localparam logic [OP_W-1:0] OP_OSC_START = 7'h4b;
   localparam logic [OP_W-1:0] OP_OSC_STOP = 7'h4d;
   localparam logic [OP_W-1:0] OP_ZQ_START = 7'h4f;
   localparam logic [OP_W-1:0] OP_ZQ_LATCH = 7'h51;
   typedef enum logic [1:0] {TCD_CMD_IDLE, TCD_CMD_MPC2, TCD_CMD_CAS2} tcd_cmd_e;
   typedef enum logic [1:0] {TCD_TR_NONE, TCD_TR_RD_FIFO, TCD_TR_RD_CAL, TCD_TR_WR_FIFO} tcd_train_e;
endpackage

/* tcd_stream_if.sv */
// valid/ready word stream between the decoder and its read buffer
`timescale 1ns/1ps
`default_nettype none
interface tcd_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* tcd_fifo.sv */
// synchronous word buffer with honest full and empty
`timescale 1ns/1ps
`default_nettype none
module tcd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   tcd_stream_if.snk fill,
   tcd_stream_if.src drain
);
   import tcd_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } tcd_fifo_s;
   tcd_fifo_s r;
   tcd_fifo_s n;
   logic push;
   logic pop;

   // flags straight from the occupancy count
   assign fill.ready = (r.count != (AW+1)'(DEPTH));
   assign drain.valid = (r.count != '0);
   assign drain.data = r.mem[r.rptr];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   // pointer and count update, wrap at any depth
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wptr] = fill.data;
         n.wptr = (r.wptr == AW'(DEPTH - 1)) ? '0 : r.wptr + 1'b1;
      end
      if (pop) begin
         n.rptr = (r.rptr == AW'(DEPTH - 1)) ? '0 : r.rptr + 1'b1;
      end
      unique case ({push, pop})
         2'b10: n.count = r.count + 1'b1;
         2'b01: n.count = r.count - 1'b1;
         default: n.count = r.count;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // tcd_fifo
`default_nettype wire

/* tcd_ctrl_model.sv */
// controller stand-in driving the command, clock-enable and data pins
`timescale 1ns/1ps
`default_nettype none
module tcd_ctrl_model #(parameter int WL = 4) (
   input wire logic clk,
   output logic cke_pin,
   output logic cs_pin,
   output logic [5:0] ca_pin,
   output logic [15:0] data_rx,
   output logic [1:0] mask_rx
);
   int cyc = 0;
   logic [17:0] at [int];
   initial begin
      cke_pin = 1'b1;
      cs_pin = 1'b0;
      ca_pin = 6'h2a;
      {mask_rx, data_rx} = 18'h0;
   end
   // released data lines invert every cycle so stale data never matches
   always @(posedge clk) begin
      cyc <= cyc + 1;
      {mask_rx, data_rx} <= at.exists(cyc) ? at[cyc] : ~{mask_rx, data_rx};
   end
   task automatic cmd(input logic [5:0] c1, input logic [5:0] c2);
      @(posedge clk);
      cs_pin <= 1'b1;
      ca_pin <= c1;
      @(posedge clk);
      cs_pin <= 1'b0;
      ca_pin <= c2;
   endtask
   // column command right after, operands low
   task automatic mpc(input logic [6:0] op, input logic cas, input int wk);
      cmd({op[6], 5'h00}, op[5:0]);
      if (cas) cmd(6'h12, 6'h00);
      // beats at write latency; no ordinary writes, so no gap needed
      if (wk >= 0) for (int b = 0; b < 16; b++) at[cyc + WL + b] = {b[1:0], 16'(wk * 256 + b)};
   endtask
endmodule // tcd_ctrl_model
`default_nettype wire

/* training_command_decoder_bench.sv */
// self-checking bench for the training command decoder
`timescale 1ns/1ps
`default_nettype none
module training_command_decoder_bench;
   import tcd_pkg::*;
   localparam int RL = 6;
   localparam int WL = 4;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cke_pin, cs_pin, data_en_b, mask_en_b, osc_running, zq_s, zq_l;
   logic [5:0] ca_pin;
   logic [15:0] data_rx, data_tx;
   logic [15:0] invert_mask = 16'h00ff;
   logic [1:0] mask_rx, mask_tx;
   logic wr_inv_en = 1'b0, rd_inv_en = 1'b0, data_mask_en = 1'b1;
   logic [7:0] pat1 = 8'ha5, pat2 = 8'h3c, res_lo, res_hi;
   int failures = 0, total_checks = 0, cycles = 0;
   int ent [5];

   tcd_ctrl_model #(.WL(WL)) ctrl_u (.clk(clk), .cke_pin(cke_pin), .cs_pin(cs_pin),
      .ca_pin(ca_pin), .data_rx(data_rx), .mask_rx(mask_rx));
   tcd_decoder #(.DQ_W(16), .RL(RL), .WL(WL), .BUF_DEPTH(8)) dut_u (.clk(clk),
      .rst_b(rst_b), .cke_pin(cke_pin), .cs_pin(cs_pin), .ca_pin(ca_pin),
      .data_rx(data_rx), .data_tx(data_tx), .data_en_b(data_en_b),
      .mask_inversion_line_rx(mask_rx), .mask_inversion_line_tx(mask_tx),
      .mask_inversion_line_en_b(mask_en_b), .first_pattern_register(pat1),
      .second_pattern_register(pat2), .invert_mask(invert_mask), .wr_inv_en(wr_inv_en),
      .rd_inv_en(rd_inv_en), .data_mask_en(data_mask_en), .osc_running(osc_running),
      .oscillator_result_low(res_lo), .oscillator_result_high(res_hi),
      .impedance_calibration_start(zq_s), .impedance_calibration_latch(zq_l));

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic t_osc();
      ctrl_u.mpc(OP_OSC_START, 1'b0, -1);
      repeat (5) @(posedge clk);
      #1 check("osc run", 24'(osc_running), 24'h1);
      repeat (45) @(posedge clk);
      // restart while running must clear the count, not carry it on
      ctrl_u.mpc(OP_OSC_START, 1'b0, -1);
      repeat (48) @(posedge clk);
      ctrl_u.mpc(OP_OSC_STOP, 1'b0, -1);
      repeat (5) @(posedge clk);
      #1 check("osc stop", 24'(osc_running), 24'h0);
      check("osc count", 24'({res_hi, res_lo} > 46 && {res_hi, res_lo} < 52), 24'h1);
   endtask

   // impedance commands act alone as one pulse
   task automatic t_zq(input logic [6:0] op, input bit lat);
      int hi = 0;
      ctrl_u.mpc(op, 1'b0, -1);
      repeat (8) begin
         @(posedge clk);
         #1 hi += lat ? zq_l : zq_s;
      end
      check("zq pulse", 24'(hi), 24'h1);
   endtask

   // no-op and reserved codes start nothing
   task automatic t_nop();
      int lo = 0;
      ctrl_u.mpc(7'h01, 1'b1, -1);
      ctrl_u.mpc(7'h45, 1'b1, -1);
      repeat (30) begin
         @(posedge clk);
         #1 lo += !data_en_b;
      end
      check("no burst", 24'(lo), 24'h0);
   endtask

   // back-to-back writes fill entries in turn
   task automatic t_write(input int n);
      for (int k = 0; k < n; k++) begin
         ctrl_u.mpc(OP_WR_FIFO, 1'b1, k);
         ent[k % 5] = k;
         repeat (12) @(posedge clk);
      end
      repeat (WL + 20) @(posedge clk);
   endtask

   // back-to-back bursts, one per column interval
   task automatic t_read(input int n, input int first, input logic [6:0] op);
      int lat = 0;
      int bb, k;
      logic bt, cal, drv;
      logic [19:0] exp;
      logic [23:0] got;
      fork
         for (int i = 0; i < n; i++) begin
            ctrl_u.mpc(op, 1'b1, -1);
            repeat (12) @(posedge clk);
         end
      join_none
      repeat (4) @(posedge clk);
      while (data_en_b !== 1'b0 && lat < 20) begin
         @(posedge clk);
         #1 lat++;
      end
      check("read latency", 24'(lat >= RL + 2 && lat <= RL + 4), 24'h1);
      for (int b = 0; b < 16 * n; b++) begin
         bb = b % 16;
         k = ent[(first + b / 16) % 5];
         bt = bb < 8 ? pat1[bb] : pat2[bb - 8];
         cal = op == OP_RD_CAL;
         drv = cal || wr_inv_en || rd_inv_en || data_mask_en;
         exp = cal ? {1'b0, {2{bt}}, 1'b0, {16{bt}} ^ invert_mask}
                   : {!drv, drv ? bb[1:0] : 2'b00, 1'b0, 16'(k * 256 + bb)};
         got = {4'h0, mask_en_b, drv ? mask_tx : 2'b00, data_en_b, data_tx};
         check("read beat", got, 24'(exp));
         @(posedge clk);
         #1;
      end
      check("burst end", 24'(data_en_b), 24'h1);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check("reset", {3'h0, data_en_b, mask_en_b, osc_running, zq_s, zq_l, res_hi, res_lo},
         24'h180000);
      t_osc();
      t_zq(OP_ZQ_START, 1'b0);
      t_zq(OP_ZQ_LATCH, 1'b1);
      // sixth write lands on the first entry
      t_write(6);
      // reads follow the writes, nothing in between
      t_read(3, 0, OP_RD_FIFO);
      t_nop();
      t_read(4, 3, OP_RD_FIFO);
      t_read(1, 0, OP_RD_CAL);
      t_read(1, 0, OP_RD_FIFO);
      @(posedge clk);
      ctrl_u.cke_pin <= 1'b0;
      repeat (4) @(posedge clk);
      ctrl_u.cke_pin <= 1'b1;
      data_mask_en <= 1'b0;
      repeat (6) @(posedge clk);
      t_read(1, 0, OP_RD_FIFO);
      // each inversion enable alone drives the mask lines
      @(posedge clk);
      wr_inv_en <= 1'b1;
      t_read(1, 1, OP_RD_FIFO);
      @(posedge clk);
      wr_inv_en <= 1'b0;
      rd_inv_en <= 1'b1;
      t_read(1, 2, OP_RD_FIFO);
      print_verdict();
   end
endmodule // training_command_decoder_bench
`default_nettype wire
